// ==== uemc_pkg.sv ====
package uemc_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int CNT_W = 24;

    // ------------------------------------------------------------------
    // Clock and documented times
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_PER_US = 1000 / CLK_PERIOD_NS;
    localparam int T_ACC_NS = 300;
    localparam int T_OE_NS = 150;
    localparam int T_DF_NS = 130;
    localparam int T_SETUP_US = 2;
    localparam int T_HOLD_US = 2;
    localparam int T_PW_US = 1000;
    localparam int T_OPW_UNIT_US = 3000;
    localparam int SYNC_STAGES = 2;

    // Least times round up to whole cycles
    localparam int T_ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_OE_CYC = (T_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_DF_CYC = (T_DF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Overprogram multiplier limits: 3 ms .. 75 ms stays inside 2.85 .. 78.75 ms
    localparam logic [4:0] OPW_MULT_MIN = 5'h01;
    localparam logic [4:0] OPW_MULT_MAX = 5'h19;

    // ------------------------------------------------------------------
    // Operations and states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_READ,
        OP_PROGRAM,
        OP_VERIFY,
        OP_ID_READ
    } uemc_op_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_SETUP,
        ST_PULSE,
        ST_HOLD,
        ST_ACCESS,
        ST_OE_WAIT,
        ST_FLOAT
    } uemc_state_e;

endpackage : uemc_pkg

// ==== uemc_tick_div.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Microsecond enable divider, restartable so timed waits start aligned
// ----------------------------------------------------------------------
module uemc_tick_div import uemc_pkg::*; #(
    parameter int P_TICK_CYC = CLK_PER_US
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_restart,
    output logic o_tick
);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        nxt_cnt = cnt_ff + CNT_W'(1);
        nxt_tick = 1'b0;
        if (i_restart) begin
            nxt_cnt = '0;
        end else if (cnt_ff == CNT_W'(P_TICK_CYC - 1)) begin
            nxt_cnt = '0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign o_tick = tick_ff;

endmodule : uemc_tick_div

// ==== uemc_host.sv ====
`timescale 1ns/1ps

// Contract
// - Host uses chip select to pick the device and hold it in standby.
// - Output gate only enables outputs and is never low without chip select.
// - Host never drives the data bus while the output gate is low.
// - Initial program pulse is low for 1.0 ms, within 0.95 to 1.05 ms.
// - Overprogram pulse is low between 2.85 ms and 78.75 ms.
// - Identification read raises high-voltage address, other lines low, byte select picks code.
// - Programming needs supply raised, chip select and strobe low, byte on outputs.
module uemc_host import uemc_pkg::*; #(
    parameter int P_TICK_CYC = CLK_PER_US,
    parameter int P_PW_US = T_PW_US,
    parameter int P_OPW_UNIT_US = T_OPW_UNIT_US
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd_op,
    input wire logic [ADDR_W-1:0] i_cmd_addr,
    input wire logic [DATA_W-1:0] i_cmd_data,
    input wire logic i_cmd_overprog,
    input wire logic [4:0] i_cmd_opw_mult,
    input wire logic [DATA_W-1:0] i_byte_outputs,
    output logic o_cmd_ready,
    output logic o_rsp_valid,
    output logic [DATA_W-1:0] o_rsp_data,
    output logic [ADDR_W-1:0] o_addr,
    output logic o_chip_select_n,
    output logic o_output_gate_n,
    output logic o_program_strobe_n,
    output logic o_program_supply_en,
    output logic o_id_high_voltage_en,
    output logic [DATA_W-1:0] o_byte_drive,
    output logic o_byte_drive_oe
);

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] din_meta_ff, din_sync_ff;

    always_ff @(posedge i_clk_sys) begin
        din_meta_ff <= i_byte_outputs;
        din_sync_ff <= din_meta_ff;
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    uemc_state_e state_ff, nxt_state;
    uemc_op_e op_ff, nxt_op;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic cnt_us_ff, nxt_cnt_us;
    logic [CNT_W-1:0] pulse_us_ff, nxt_pulse_us;
    logic overprog_ff, nxt_overprog;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic ce_n_ff, nxt_ce_n;
    logic oe_n_ff, nxt_oe_n;
    logic pgm_n_ff, nxt_pgm_n;
    logic vpp_ff, nxt_vpp;
    logic idhv_ff, nxt_idhv;
    logic [DATA_W-1:0] dout_ff, nxt_dout;
    logic doe_ff, nxt_doe;
    logic ready_ff, nxt_ready;
    logic rsp_valid_ff, nxt_rsp_valid;
    logic [DATA_W-1:0] rsp_data_ff, nxt_rsp_data;
    logic restart, tick, cnt_done;
    logic [4:0] mult;
    uemc_tick_div #(.P_TICK_CYC(P_TICK_CYC)) u_tick (
        .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_restart(restart), .o_tick(tick)
    );
    assign cnt_done = (cnt_ff == '0);

    always_comb begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_cnt = cnt_ff;
        nxt_cnt_us = cnt_us_ff;
        nxt_pulse_us = pulse_us_ff;
        nxt_overprog = overprog_ff;
        nxt_addr = addr_ff;
        nxt_ce_n = ce_n_ff;
        nxt_oe_n = oe_n_ff;
        nxt_pgm_n = pgm_n_ff;
        nxt_vpp = vpp_ff;
        nxt_idhv = idhv_ff;
        nxt_dout = dout_ff;
        nxt_doe = doe_ff;
        nxt_ready = ready_ff;
        nxt_rsp_valid = 1'b0;
        nxt_rsp_data = rsp_data_ff;
        restart = 1'b0;
        mult = (i_cmd_opw_mult < OPW_MULT_MIN) ? OPW_MULT_MIN :
               ((i_cmd_opw_mult > OPW_MULT_MAX) ? OPW_MULT_MAX : i_cmd_opw_mult);
        if (!cnt_done && (!cnt_us_ff || tick)) begin
            nxt_cnt = cnt_ff - CNT_W'(1);
        end
        unique case (state_ff)
            ST_IDLE: begin
                if (i_cmd_valid && ready_ff) begin
                    nxt_op = uemc_op_e'(i_cmd_op);
                    nxt_ready = 1'b0;
                    nxt_overprog = i_cmd_overprog;
                    nxt_pulse_us = i_cmd_overprog ? CNT_W'(P_OPW_UNIT_US * int'(mult)) : CNT_W'(P_PW_US);
                    nxt_addr = i_cmd_addr;
                    nxt_dout = i_cmd_data;
                    if (uemc_op_e'(i_cmd_op) == OP_ID_READ) begin
                        nxt_addr = {{(ADDR_W - 1){1'b0}}, i_cmd_addr[0]};
                        nxt_idhv = 1'b1;
                    end
                    if (uemc_op_e'(i_cmd_op) == OP_READ) begin
                        nxt_ce_n = 1'b0;
                        nxt_state = ST_ACCESS;
                        nxt_cnt = CNT_W'(T_ACC_CYC);
                        nxt_cnt_us = 1'b0;
                    end else begin
                        nxt_vpp = (uemc_op_e'(i_cmd_op) != OP_ID_READ);
                        nxt_state = ST_SETTLE;
                        nxt_cnt = CNT_W'(T_SETUP_US);
                        nxt_cnt_us = 1'b1;
                        restart = 1'b1;
                    end
                end
            end
            ST_SETTLE: begin
                if (cnt_done) begin
                    nxt_ce_n = 1'b0;
                    if (op_ff == OP_PROGRAM) begin
                        nxt_doe = 1'b1;
                        nxt_state = ST_SETUP;
                        nxt_cnt = CNT_W'(T_SETUP_US);
                        nxt_cnt_us = 1'b1;
                        restart = 1'b1;
                    end else begin
                        nxt_state = ST_ACCESS;
                        nxt_cnt = CNT_W'(T_ACC_CYC);
                        nxt_cnt_us = 1'b0;
                    end
                end
            end
            ST_SETUP: begin
                if (cnt_done) begin
                    nxt_pgm_n = 1'b0;
                    nxt_state = ST_PULSE;
                    nxt_cnt = pulse_us_ff;
                    nxt_cnt_us = 1'b1;
                    restart = 1'b1;
                end
            end
            ST_PULSE: begin
                if (cnt_done) begin
                    nxt_pgm_n = 1'b1;
                    nxt_state = ST_HOLD;
                    nxt_cnt = CNT_W'(T_HOLD_US);
                    nxt_cnt_us = 1'b1;
                    restart = 1'b1;
                end
            end
            ST_HOLD: begin
                if (cnt_done) begin
                    nxt_doe = 1'b0;
                    nxt_ce_n = 1'b1;
                    nxt_state = ST_FLOAT;
                    nxt_cnt = CNT_W'(T_DF_CYC);
                    nxt_cnt_us = 1'b0;
                end
            end
            ST_ACCESS: begin
                if (cnt_done) begin
                    nxt_oe_n = 1'b0;
                    nxt_state = ST_OE_WAIT;
                    nxt_cnt = CNT_W'(T_OE_CYC + SYNC_STAGES);
                    nxt_cnt_us = 1'b0;
                end
            end
            ST_OE_WAIT: begin
                if (cnt_done) begin
                    nxt_rsp_data = din_sync_ff;
                    nxt_rsp_valid = 1'b1;
                    nxt_oe_n = 1'b1;
                    nxt_ce_n = 1'b1;
                    nxt_state = ST_FLOAT;
                    nxt_cnt = CNT_W'(T_DF_CYC);
                    nxt_cnt_us = 1'b0;
                end
            end
            ST_FLOAT: begin
                if (cnt_done) begin
                    nxt_vpp = 1'b0;
                    nxt_idhv = 1'b0;
                    nxt_ready = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_ff <= ST_IDLE;
            op_ff <= OP_READ;
            cnt_ff <= '0;
            cnt_us_ff <= 1'b0;
            pulse_us_ff <= '0;
            overprog_ff <= 1'b0;
            addr_ff <= '0;
            ce_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            pgm_n_ff <= 1'b1;
            vpp_ff <= 1'b0;
            idhv_ff <= 1'b0;
            dout_ff <= '0;
            doe_ff <= 1'b0;
            ready_ff <= 1'b1;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            cnt_ff <= nxt_cnt;
            cnt_us_ff <= nxt_cnt_us;
            pulse_us_ff <= nxt_pulse_us;
            overprog_ff <= nxt_overprog;
            addr_ff <= nxt_addr;
            ce_n_ff <= nxt_ce_n;
            oe_n_ff <= nxt_oe_n;
            pgm_n_ff <= nxt_pgm_n;
            vpp_ff <= nxt_vpp;
            idhv_ff <= nxt_idhv;
            dout_ff <= nxt_dout;
            doe_ff <= nxt_doe;
            ready_ff <= nxt_ready;
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_data_ff <= nxt_rsp_data;
        end
    end

    assign o_cmd_ready = ready_ff;
    assign o_rsp_valid = rsp_valid_ff;
    assign o_rsp_data = rsp_data_ff;
    assign o_addr = addr_ff;
    assign o_chip_select_n = ce_n_ff;
    assign o_output_gate_n = oe_n_ff;
    assign o_program_strobe_n = pgm_n_ff;
    assign o_program_supply_en = vpp_ff;
    assign o_id_high_voltage_en = idhv_ff;
    assign o_byte_drive = dout_ff;
    assign o_byte_drive_oe = doe_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] low_cnt_ff, oe_cnt_ff;

    always_ff @(posedge i_clk_sys) begin
        low_cnt_ff <= (i_srst || pgm_n_ff) ? '0 : low_cnt_ff + CNT_W'(1);
        oe_cnt_ff <= (i_srst || oe_n_ff) ? '0 : oe_cnt_ff + CNT_W'(1);
    end

    a_ce_idle_standby: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        state_ff == ST_IDLE |-> ce_n_ff) else $error("chip select low while idle");
    a_oe_needs_ce: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        !oe_n_ff |-> !ce_n_ff) else $error("output gate low without chip select");
    a_no_bus_fight: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        !oe_n_ff |-> !doe_ff) else $error("host drives bus while output gate low");
    a_init_pulse_len: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        $rose(pgm_n_ff) && !overprog_ff |->
        low_cnt_ff >= CNT_W'(P_PW_US * P_TICK_CYC) && low_cnt_ff <= CNT_W'(P_PW_US * P_TICK_CYC + 2))
        else $error("initial program pulse width wrong");
    a_over_pulse_len: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        $rose(pgm_n_ff) && overprog_ff |->
        low_cnt_ff >= CNT_W'(P_OPW_UNIT_US * P_TICK_CYC) && low_cnt_ff <= pulse_us_ff * CNT_W'(P_TICK_CYC) + CNT_W'(2))
        else $error("overprogram pulse width wrong");
    a_id_addr_low: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        idhv_ff && !ce_n_ff |-> addr_ff[ADDR_W-1:1] == '0 && !vpp_ff && pgm_n_ff)
        else $error("identification read with bad address or supply");
    a_prog_conditions: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        $fell(pgm_n_ff) |-> vpp_ff && !ce_n_ff && oe_n_ff && doe_ff ##1 (!pgm_n_ff && doe_ff && vpp_ff) [*2])
        else $error("program pulse without supply, select or data");
    a_sample_after_oe: assert property (@(posedge i_clk_sys) disable iff (i_srst)
        $rose(rsp_valid_ff) |-> oe_cnt_ff >= CNT_W'(T_OE_CYC + SYNC_STAGES))
        else $error("data sampled before output gate delay");

endmodule : uemc_host

// ==== uemc_eprom_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Behavioural memory device on the far side of the host controller
// ----------------------------------------------------------------------
module uemc_eprom_model import uemc_pkg::*; #(
    parameter logic [7:0] P_MAKER_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] P_TYPE_CODE = 8'h3c // Arbitrary value
) (
    input wire logic i_clk_sys,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_chip_select_n,
    input wire logic i_output_gate_n,
    input wire logic i_program_strobe_n,
    input wire logic i_program_supply_en,
    input wire logic i_id_high_voltage_en,
    input wire logic i_host_drive_oe,
    input wire logic [DATA_W-1:0] i_bus_level,
    output logic [DATA_W-1:0] o_byte_outputs,
    output logic o_driving,
    output logic [31:0] o_last_pw
);
    logic [DATA_W-1:0] mem_ff [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] last_ff = 8'hff;
    logic [31:0] last_pw_ff = 32'h0;
    logic [7:0] valid_cnt_ff = 8'h00;
    logic [31:0] low_cnt_ff = 32'h0;
    logic sel_read;
    logic id_mode;
    logic [DATA_W-1:0] rd_byte;

    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            mem_ff[i] = 8'hff;
        end
    end

    assign sel_read = !i_chip_select_n && !i_output_gate_n && i_program_strobe_n;
    assign id_mode = i_id_high_voltage_en && (i_addr[ADDR_W-1:1] == '0);
    assign rd_byte = id_mode ? (i_addr[0] ? P_TYPE_CODE : P_MAKER_CODE) : mem_ff[i_addr];
    // Data only turns valid once the output gate delay has run
    assign o_driving = sel_read && (valid_cnt_ff >= 8'(T_OE_CYC));
    // Floating outputs show the inverse of the last byte, never a stale match
    assign o_byte_outputs = o_driving ? rd_byte : ~last_ff;
    assign o_last_pw = last_pw_ff;

    always @(posedge i_clk_sys) begin
        if (!sel_read) begin
            valid_cnt_ff <= 8'h00;
        end else if (valid_cnt_ff != 8'hff) begin
            valid_cnt_ff <= valid_cnt_ff + 8'h01;
        end
        if (o_driving) begin
            last_ff <= rd_byte;
        end
        if (i_program_supply_en && !i_chip_select_n && !i_program_strobe_n && i_host_drive_oe) begin
            mem_ff[i_addr] <= mem_ff[i_addr] & i_bus_level;
        end
        if (!i_program_strobe_n) begin
            low_cnt_ff <= low_cnt_ff + 32'h1;
        end else if (low_cnt_ff != 32'h0) begin
            last_pw_ff <= low_cnt_ff;
            low_cnt_ff <= 32'h0;
        end
    end
endmodule : uemc_eprom_model

// ==== test_uv_eprom_mode_control.sv ====
`timescale 1ns/1ps

module test_uv_eprom_mode_control import uemc_pkg::*;;
    localparam int TICK = 4;
    localparam int PW = 100;
    localparam int OPW = 300;
    localparam logic [7:0] MAKER = 8'h5a;
    localparam logic [7:0] TYPE = 8'h3c;

    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [ADDR_W-1:0] cmd_addr = '0;
    logic [DATA_W-1:0] cmd_data = '0;
    logic cmd_overprog = 1'b0;
    logic [4:0] cmd_mult = 5'h00;
    logic rdy, rsp_valid, ce_n, oe_n, strobe_n, supply_en, idhv, drive_oe, driving;
    logic [DATA_W-1:0] rsp_data, byte_drive, model_out, bus_level;
    logic [ADDR_W-1:0] addr;
    logic [31:0] last_pw;
    int bad_count = 0;
    int n_checks = 0;
    int n_pulses = 0;
    logic strobe_d = 1'b1;
    logic sup_seen;

    assign bus_level = drive_oe ? byte_drive : model_out;

    uemc_host #(.P_TICK_CYC(TICK), .P_PW_US(PW), .P_OPW_UNIT_US(OPW)) dut_u (
        .i_clk_sys(clk), .i_srst(srst), .i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op),
        .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data), .i_cmd_overprog(cmd_overprog),
        .i_cmd_opw_mult(cmd_mult), .i_byte_outputs(bus_level), .o_cmd_ready(rdy),
        .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_addr(addr), .o_chip_select_n(ce_n),
        .o_output_gate_n(oe_n), .o_program_strobe_n(strobe_n), .o_program_supply_en(supply_en),
        .o_id_high_voltage_en(idhv), .o_byte_drive(byte_drive), .o_byte_drive_oe(drive_oe));

    uemc_eprom_model #(.P_MAKER_CODE(MAKER), .P_TYPE_CODE(TYPE)) mem_u (
        .i_clk_sys(clk), .i_addr(addr), .i_chip_select_n(ce_n), .i_output_gate_n(oe_n),
        .i_program_strobe_n(strobe_n), .i_program_supply_en(supply_en), .i_id_high_voltage_en(idhv),
        .i_host_drive_oe(drive_oe), .i_bus_level(bus_level), .o_byte_outputs(model_out),
        .o_driving(driving), .o_last_pw(last_pw));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (exp !== got) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------------
    // Pin-level watch on the host side
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        strobe_d <= strobe_n;
        if (!srst) begin
            chk("gate_without_select", 1'b0, 32'(!oe_n && ce_n));
            chk("drive_while_gated", 1'b0, 32'(drive_oe && !oe_n));
            chk("strobe_outside_program", 1'b0, 32'(!strobe_n && !(supply_en && !ce_n && drive_oe)));
            // Completed strobe pulses, so a missing pulse cannot reuse an old width
            if (strobe_n === 1'b1 && strobe_d === 1'b0) begin
                n_pulses++;
            end
        end
    end

    // ------------------------------------------------------------------
    // Command tasks
    // ------------------------------------------------------------------
    task automatic do_cmd(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                          input logic ovp, input logic [4:0] m, output logic [7:0] rsp, output logic seen);
        int n;
        n = 0;
        seen = 1'b0;
        rsp = 8'h00;
        sup_seen = 1'bx;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_overprog <= ovp;
        cmd_mult <= m;
        @(posedge clk);
        cmd_valid <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (rsp_valid === 1'b1) begin
                seen = 1'b1;
                rsp = rsp_data;
                sup_seen = supply_en;
            end
        end while (rdy !== 1'b1 && n < 40000);
        if (n >= 40000) begin
            chk("command_completion", 1'b1, 1'b0);
        end
    endtask : do_cmd

    task automatic rd(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        logic [7:0] r;
        logic s;
        do_cmd(op, a, 8'h00, 1'b0, 5'h00, r, s);
        chk("response_seen", 1'b1, 32'(s));
        chk("response_byte", 32'(exp), 32'(r));
        chk("supply_at_sample", 32'(op == OP_VERIFY), 32'(sup_seen));
    endtask : rd

    task automatic pg(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic ovp,
                      input logic [4:0] m, input int lo, input int hi);
        logic [7:0] r;
        logic s;
        int p0;
        logic [31:0] pw_seen;
        p0 = n_pulses;
        do_cmd(2'h1, a, d, ovp, m, r, s);
        chk("program_no_response", 1'b0, 32'(s));
        chk("strobe_pulses", 32'(p0 + 1), 32'(n_pulses));
        // In range reads as the low bound; an unknown width stays unknown and mismatches
        pw_seen = (last_pw >= 32'(lo) && last_pw <= 32'(hi)) ? 32'(lo) : last_pw;
        chk("strobe_low_cycles", 32'(lo), pw_seen);
    endtask : pg

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic erased_read();
        rd(OP_READ, 13'h1fff, 8'hff);
        rd(OP_READ, 13'h0000, 8'hff);
    endtask : erased_read

    task automatic initial_program();
        pg(13'h0123, 8'ha5, 1'b0, 5'h00, PW * TICK * 95 / 100, PW * TICK * 105 / 100);
        rd(OP_VERIFY, 13'h0123, 8'ha5);
        rd(OP_READ, 13'h0124, 8'hff);
    endtask : initial_program

    task automatic over_program();
        pg(13'h0123, 8'h5f, 1'b1, 5'h01, OPW * TICK, OPW * TICK + 8);
        rd(OP_VERIFY, 13'h0123, 8'h05);
        pg(13'h0456, 8'h3c, 1'b1, 5'h00, OPW * TICK, OPW * TICK + 8);
        pg(13'h0456, 8'hc3, 1'b1, 5'h1f, 25 * OPW * TICK, 25 * OPW * TICK + 8);
        rd(OP_READ, 13'h0456, 8'h00);
    endtask : over_program

    task automatic signature_read();
        rd(OP_ID_READ, 13'h1ffe, MAKER);
        rd(OP_ID_READ, 13'h1fff, TYPE);
        rd(OP_READ, 13'h1ffe, 8'hff);
    endtask : signature_read

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("idle_pins", 32'h1f, {27'h0, rdy, ce_n, oe_n, strobe_n, 1'b1});
        chk("idle_supply", 32'h0, {29'h0, supply_en, idhv, drive_oe});
        erased_read();
        initial_program();
        over_program();
        signature_read();
        finish_test();
    end

    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        finish_test();
    end
endmodule : test_uv_eprom_mode_control
